// ==== inc/bec_pkg.sv ====
// Package of constants for the byte nonvolatile memory controller
`default_nettype none
package bec_pkg;
    // ------------------------------------------------------------
    // Register byte addresses on the AXI4-Lite slave
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ADDR = 8'h04;
    localparam logic [7:0] ADDR_DATA = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    // ------------------------------------------------------------
    // Control and status register field positions
    // ------------------------------------------------------------
    localparam int BIT_READ = 0;
    localparam int BIT_GO = 1;
    localparam int BIT_UNLOCK = 2;
    localparam int BIT_IRQ_EN = 3;
    localparam int BIT_KIND_LO = 4;
    localparam int BIT_KIND_HI = 5;
    localparam int BIT_STALL = 0;
    // ------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------
    localparam logic [1:0] KIND_RESET = 2'h0;
    localparam logic [1:0] KIND_ATOMIC = 2'h0;
    localparam logic [1:0] KIND_ERASE = 2'h1;
    localparam logic [1:0] KIND_WRITE = 2'h2;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40000000;
    localparam int OSC_HZ = 8000000;
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;
    localparam int ATOMIC_US = 3400;
    localparam int SPLIT_US = 1800;
    localparam int ATOMIC_TICKS = ATOMIC_US * (OSC_HZ / 1000000);
    localparam int SPLIT_TICKS = SPLIT_US * (OSC_HZ / 1000000);
    localparam int UNLOCK_CYCLES = 4;
    localparam int READ_STALL = 4;
    localparam int PROG_STALL = 2;
endpackage
`default_nettype wire

// ==== logic/bec_ctrl.sv ====
// Byte nonvolatile memory controller with an AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none
module bec_ctrl #(
    parameter int ADDR_W = 7,
    parameter int ATOMIC_T = bec_pkg::ATOMIC_TICKS,
    parameter int SPLIT_T = bec_pkg::SPLIT_TICKS
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Power-on reset, clears programming state too
    input wire logic i_por_n,
    // Global interrupt enable of the core
    input wire logic i_gie,
    // AXI4-Lite write address and data
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // AXI4-Lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // Core side
    output logic o_stall,
    output logic o_ready_irq
);
    localparam int DEPTH = 1 << ADDR_W;
    // Wide enough for the longest programming count, so no timer bits are lost
    localparam int CW = $clog2(ATOMIC_T + 1);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {BEC_IDLE, BEC_ERASE, BEC_PROG} bec_phase_type;

    logic [7:0] mem_reg [DEPTH];
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [7:0] data_reg, data_next;
    logic [1:0] kind_reg, kind_next;
    logic irq_en_reg, irq_en_next;
    logic unlock_reg, unlock_next;
    logic [2:0] unlock_cnt_reg, unlock_cnt_next;
    logic busy_reg, busy_next;
    bec_phase_type phase_reg, phase_next;
    logic [CW-1:0] tick_cnt_reg, tick_cnt_next;
    logic [2:0] div_reg, div_next;
    logic [2:0] stall_cnt_reg, stall_cnt_next;
    logic stall_reg, irq_reg;
    logic awready_reg, wready_reg, arready_reg;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic osc_tick;

    logic aw_reg, aw_next, w_reg, w_next;
    logic [7:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic wr_fire, rd_fire;
    logic [31:0] ctrl_view;

    // ------------------------------------------------------------
    // Timing tick from the clock divider
    // ------------------------------------------------------------
    // Stands in for the internal oscillator: one pulse per 125 ns
    always_comb begin
        div_next = (div_reg == 3'(bec_pkg::OSC_DIV - 1)) ? 3'h0 : div_reg + 3'h1;
        osc_tick = (div_reg == 3'(bec_pkg::OSC_DIV - 1));
    end

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    assign o_awready = awready_reg;
    assign o_wready = wready_reg;
    assign o_arready = arready_reg;
    assign o_bvalid = bvalid_reg;
    assign o_bresp = bresp_reg;
    assign o_rvalid = rvalid_reg;
    assign o_rdata = rdata_reg;
    assign o_rresp = rresp_reg;
    assign o_stall = stall_reg;
    assign o_ready_irq = irq_reg;

    // Address and data may arrive in either order; write fires once both held
    always_comb begin
        aw_next = aw_reg;
        w_next = w_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        if (i_awvalid && !aw_reg) begin
            aw_next = 1'b1;
            awaddr_next = i_awaddr;
        end
        if (i_wvalid && !w_reg) begin
            w_next = 1'b1;
            wdata_next = i_wdata;
            wstrb_next = i_wstrb;
        end
        wr_fire = aw_reg && w_reg && !bvalid_reg;
        if (wr_fire) begin
            aw_next = 1'b0;
            w_next = 1'b0;
        end
        rd_fire = i_arvalid && !rvalid_reg;
    end

    // ------------------------------------------------------------
    // Register file and programming engine
    // ------------------------------------------------------------
    always_comb begin
        ctrl_view = 32'h0;
        ctrl_view[bec_pkg::BIT_GO] = busy_reg;
        ctrl_view[bec_pkg::BIT_UNLOCK] = unlock_reg;
        ctrl_view[bec_pkg::BIT_IRQ_EN] = irq_en_reg;
        ctrl_view[bec_pkg::BIT_KIND_LO] = kind_reg[0];
        ctrl_view[bec_pkg::BIT_KIND_HI] = kind_reg[1];
    end

    always_comb begin
        addr_next = addr_reg;
        data_next = data_reg;
        kind_next = kind_reg;
        irq_en_next = irq_en_reg;
        unlock_next = unlock_reg;
        unlock_cnt_next = unlock_cnt_reg;
        busy_next = busy_reg;
        phase_next = phase_reg;
        tick_cnt_next = tick_cnt_reg;
        stall_cnt_next = (stall_cnt_reg != 3'h0) ? stall_cnt_reg - 3'h1 : 3'h0;
        mem_we = 1'b0;
        mem_wdata = data_reg;
        bvalid_next = bvalid_reg && !i_bready;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg && !i_rready;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        // Unlock window closes by itself
        if (unlock_reg) begin
            if (unlock_cnt_reg == 3'(bec_pkg::UNLOCK_CYCLES - 1)) begin
                unlock_next = 1'b0;
            end else begin
                unlock_cnt_next = unlock_cnt_reg + 3'h1;
            end
        end
        // Program timing runs on oscillator ticks only
        if (busy_reg && osc_tick) begin
            if (tick_cnt_reg > CW'(1)) begin
                tick_cnt_next = tick_cnt_reg - CW'(1);
            end else if (phase_reg == BEC_ERASE && kind_reg == bec_pkg::KIND_ATOMIC) begin
                // Atomic: erase half done, now program the new byte
                mem_we = 1'b1;
                mem_wdata = bec_pkg::ERASED_BYTE;
                phase_next = BEC_PROG;
                tick_cnt_next = CW'(ATOMIC_T - SPLIT_T);
            end else begin
                mem_we = 1'b1;
                mem_wdata = (phase_reg == BEC_ERASE) ? bec_pkg::ERASED_BYTE
                                                    : (mem_reg[addr_reg] & data_reg);
                phase_next = BEC_IDLE;
                busy_next = 1'b0;
            end
        end
        // Register writes
        if (wr_fire) begin
            bvalid_next = 1'b1;
            bresp_next = bec_pkg::RESP_OKAY;
            if (awaddr_reg == bec_pkg::ADDR_CTRL && wstrb_reg[0]) begin
                if (!busy_reg) begin
                    kind_next = {wdata_reg[bec_pkg::BIT_KIND_HI],
                                 wdata_reg[bec_pkg::BIT_KIND_LO]};
                end
                irq_en_next = wdata_reg[bec_pkg::BIT_IRQ_EN];
                if (wdata_reg[bec_pkg::BIT_UNLOCK] && !unlock_reg) begin
                    unlock_next = 1'b1;
                    unlock_cnt_next = 3'h0;
                end
                if (wdata_reg[bec_pkg::BIT_GO] && unlock_reg && !busy_reg
                    && kind_next != 2'h3) begin
                    busy_next = 1'b1;
                    unlock_next = 1'b0;
                    stall_cnt_next = 3'(bec_pkg::PROG_STALL);
                    // Mode 11 is refused above; write only skips erase
                    phase_next = (kind_next == bec_pkg::KIND_WRITE) ? BEC_PROG : BEC_ERASE;
                    tick_cnt_next = (kind_next == bec_pkg::KIND_ATOMIC) ? CW'(SPLIT_T)
                                                                        : CW'(SPLIT_T);
                end else if (wdata_reg[bec_pkg::BIT_READ] && !busy_reg) begin
                    // Read strobe is never stored, so it needs no clearing
                    data_next = mem_reg[addr_reg];
                    stall_cnt_next = 3'(bec_pkg::READ_STALL);
                end
            end else if (awaddr_reg == bec_pkg::ADDR_ADDR && wstrb_reg[0]) begin
                if (!busy_reg) begin
                    addr_next = wdata_reg[ADDR_W-1:0];
                end
            end else if (awaddr_reg == bec_pkg::ADDR_DATA && wstrb_reg[0]) begin
                data_next = wdata_reg[7:0];
            end else if (awaddr_reg != bec_pkg::ADDR_CTRL && awaddr_reg != bec_pkg::ADDR_ADDR
                         && awaddr_reg != bec_pkg::ADDR_DATA) begin
                bresp_next = bec_pkg::RESP_SLVERR;
            end
        end
        // Register reads
        if (rd_fire) begin
            rvalid_next = 1'b1;
            rresp_next = bec_pkg::RESP_OKAY;
            unique case (i_araddr)
                bec_pkg::ADDR_CTRL: rdata_next = ctrl_view;
                bec_pkg::ADDR_ADDR: rdata_next = 32'(addr_reg);
                bec_pkg::ADDR_DATA: rdata_next = {24'h0, data_reg};
                bec_pkg::ADDR_STAT: rdata_next = {31'h0, stall_reg};
                default: begin
                    rdata_next = 32'h0;
                    rresp_next = bec_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Programming state survives system reset, only power-on clears it
    always_ff @(posedge i_ref_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            busy_reg <= 1'b0;
            phase_reg <= BEC_IDLE;
            tick_cnt_reg <= '0;
            div_reg <= 3'h0;
        end else begin
            busy_reg <= busy_next;
            phase_reg <= phase_next;
            tick_cnt_reg <= tick_cnt_next;
            div_reg <= div_next;
        end
    end

    // Address and data must outlive a reset that lands mid programming
    always_ff @(posedge i_ref_clk) begin
        if (mem_we) begin
            mem_reg[addr_reg] <= mem_wdata;
        end
        if (!i_rst_n) begin
            if (!busy_reg) begin
                kind_reg <= bec_pkg::KIND_RESET;
            end
        end else begin
            addr_reg <= addr_next;
            data_reg <= data_next;
            kind_reg <= kind_next;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_en_reg <= 1'b0;
            unlock_reg <= 1'b0;
            unlock_cnt_reg <= 3'h0;
            stall_cnt_reg <= 3'h0;
            stall_reg <= 1'b0;
            irq_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            arready_reg <= 1'b1;
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            awaddr_reg <= 8'h0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= 2'h0;
        end else begin
            irq_en_reg <= irq_en_next;
            unlock_reg <= unlock_next;
            unlock_cnt_reg <= unlock_cnt_next;
            stall_cnt_reg <= stall_cnt_next;
            stall_reg <= (stall_cnt_next != 3'h0);
            irq_reg <= irq_en_next && i_gie && !busy_next;
            // Ready flags kept as flops so the bus sees no logic after a register
            awready_reg <= !aw_next;
            wready_reg <= !w_next;
            arready_reg <= !rvalid_next;
            aw_reg <= aw_next;
            w_reg <= w_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end
endmodule // bec_ctrl
`default_nettype wire

// ==== verif/bec_ctrl_props.sv ====
// Port-level assertions for the byte nonvolatile memory controller
`default_nettype none
module bec_ctrl_props #(
    parameter int ADDR_W = 7
) (
    // Clock, reset and core side
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_gie,
    input wire logic o_stall,
    input wire logic o_ready_irq,
    // Bus handshakes watched
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [7:0] i_araddr,
    input wire logic o_rvalid,
    input wire logic [31:0] o_rdata
);
    logic [7:0] ar_reg;
    logic [3:0] age_reg;
    logic rd_ctl;
    // Last read address, and cycles since the last write request; saturates so it never wraps
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ar_reg <= 8'h00;
            age_reg <= 4'hF;
        end else begin
            ar_reg <= (i_arvalid && o_arready) ? i_araddr : ar_reg;
            age_reg <= (i_awvalid && o_awready) ? 4'h0 : age_reg + 4'(age_reg != 4'hF);
        end
    end
    assign rd_ctl = o_rvalid && (ar_reg == bec_pkg::ADDR_CTRL);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // -------------------------------------------------------------
    // Properties
    // -------------------------------------------------------------
    property p_stall_len; $rose(o_stall) |-> o_stall[*2] ##1 (!o_stall or o_stall[*2] ##1 !o_stall); endproperty
    property p_stall_max; o_stall[*4] |=> !o_stall; endproperty
    property p_stall_cause; $rose(o_stall) |-> age_reg <= 4'h6; endproperty
    property p_irq_gie; o_ready_irq |-> $past(i_gie); endproperty
    property p_rd_hi; o_rvalid |-> o_rdata[31:8] == 24'h000000; endproperty
    property p_rd_strobe; rd_ctl |-> !o_rdata[bec_pkg::BIT_READ]; endproperty
    property p_ctl_rsvd; rd_ctl |-> o_rdata[7:6] == 2'h0; endproperty
    property p_addr_w; o_rvalid && ar_reg == bec_pkg::ADDR_ADDR |-> (o_rdata[7:0] >> ADDR_W) == 8'h00; endproperty
    a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
    a_stall_max: assert property (p_stall_max) else $error("stall too long");
    a_stall_cause: assert property (p_stall_cause) else $error("stall without request");
    a_irq_gie: assert property (p_irq_gie) else $error("irq without global enable");
    a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
    a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe stuck");
    a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("reserved control bits set");
    a_addr_w: assert property (p_addr_w) else $error("address wider than array");
    cover property ($rose(o_stall));
    cover property (o_ready_irq);
    cover property (rd_ctl);
endmodule // bec_ctrl_props
bind bec_ctrl bec_ctrl_props #(.ADDR_W(ADDR_W)) u_props (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_gie(i_gie),
    .o_stall(o_stall), .o_ready_irq(o_ready_irq), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr), .o_rvalid(o_rvalid),
    .o_rdata(o_rdata)
);
`default_nettype wire

// ==== verif/bec_ctrl_tb.sv ====
// Self-checking bench for the byte nonvolatile memory controller
`default_nettype none
module bec_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] C = bec_pkg::ADDR_CTRL, A = bec_pkg::ADDR_ADDR, D = bec_pkg::ADDR_DATA;
    localparam logic [1:0] KA = bec_pkg::KIND_ATOMIC, KE = bec_pkg::KIND_ERASE;
    localparam logic [1:0] KW = bec_pkg::KIND_WRITE;
    localparam int DV = bec_pkg::OSC_DIV, AT = 20, ST = 10;
    logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_por_n = 1'b0, i_gie = 1'b0;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_arvalid = 1'b0, i_bready = 1'b1, i_rready = 1'b1;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic [3:0] i_wstrb = 4'h1, xb = 4'h0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_stall, o_ready_irq;
    logic [1:0] o_bresp, o_rresp, r;
    logic [31:0] o_rdata, d;
    int bad_count = 0, samples_checked = 0, cyc = 0, t0 = 0;
    // Short program times keep the run brief; expectations scale from them
    bec_ctrl #(.ADDR_W(7), .ATOMIC_T(AT), .SPLIT_T(ST)) dut (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_por_n(i_por_n), .i_gie(i_gie),
        .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid),
        .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .o_bvalid(o_bvalid),
        .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready),
        .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
        .o_rresp(o_rresp), .o_stall(o_stall), .o_ready_irq(o_ready_irq)
    );
    // 40 MHz clock and a free cycle count
    always #12.5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) cyc <= cyc + 1;
    // -------------------------------------------------------------
    // Bus tasks; each starts just after an edge so back-to-back calls stay tight
    // -------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        i_awaddr <= a;
        i_wdata <= v;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            // Drop each valid only once, so a following call can raise it cleanly
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
        end while (o_bvalid !== 1'b1);
        rs = o_bresp;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
        end while (o_rvalid !== 1'b1);
        v = o_rdata;
        rs = o_rresp;
    endtask
    task automatic wv(input logic [7:0] a, input logic [31:0] v);
        logic [1:0] rs;
        wr(a, v, rs);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0] rs;
        rd(a, v, rs);
        chk(v, e);
    endtask
    // Control write: kind in bits 5:4, then irq enable, unlock, go, read strobe
    task automatic cw(input logic [1:0] k, input logic [3:0] b);
        wv(C, {26'h0, k, b | xb});
    endtask
    // Full program sequence, unlock and go on consecutive writes
    task automatic prog(input logic [1:0] k, input logic [7:0] a, input logic [7:0] v);
        cw(k, 4'h0);
        wv(A, {24'h0, a});
        wv(D, {24'h0, v});
        cw(k, 4'h4);
        cw(k, 4'h6);
        t0 = cyc;
    endtask
    // Poll busy until clear and check the busy span against the tick count
    task automatic span(input int n);
        logic [31:0] v;
        logic [1:0] rs;
        do rd(C, v, rs); while (v[1] !== 1'b0);
        chk(32'(cyc - t0 >= n - 8 && cyc - t0 <= n + 24), 32'h1);
    endtask
    task automatic rb(input logic [7:0] a, input logic [31:0] e);
        wv(A, {24'h0, a});
        cw(KA, 4'h1);
        rc(bec_pkg::ADDR_STAT, 32'h1);
        rc(D, e);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        repeat (3) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        i_por_n <= 1'b1;
        @(posedge i_ref_clk);
        rc(C, 32'h0);
        rd(8'h10, d, r);
        chk({30'h0, r}, {30'h0, bec_pkg::RESP_SLVERR});
        wr(8'h14, 32'h1, r);
        chk({30'h0, r}, {30'h0, bec_pkg::RESP_SLVERR});
        prog(KA, 8'h05, 8'h3C);
        rd(C, d, r);
        chk({31'h0, d[1]}, 32'h1);
        wv(A, 32'h7F);
        cw(KE, 4'h1);
        span(DV * AT);
        rc(A, 32'h05);
        rc(C, 32'h0);
        rb(8'h05, 32'h3C);
        prog(KE, 8'h05, 8'h00);
        span(DV * ST);
        rb(8'h05, {24'h0, bec_pkg::ERASED_BYTE});
        prog(KW, 8'h05, 8'hA5);
        span(DV * ST);
        rb(8'h05, 32'hA5);
        cw(KE, 4'h4);
        repeat (6) @(posedge i_ref_clk);
        rc(C, 32'h10);
        cw(KE, 4'h2);
        rc(C, 32'h10);
        prog(2'h3, 8'h05, 8'h00);
        repeat (6) @(posedge i_ref_clk);
        rc(C, 32'h30);
        rb(8'h05, 32'hA5);
        prog(KA, 8'h7F, 8'h5A);
        repeat (4) @(posedge i_ref_clk);
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        @(posedge i_ref_clk);
        rd(C, d, r);
        chk({31'h0, d[1]}, 32'h1);
        span(DV * AT);
        rb(8'h7F, 32'h5A);
        wv(A, 32'hFF);
        rc(A, 32'h7F);
        i_gie <= 1'b1;
        xb = 4'h8;
        cw(KA, 4'h0);
        repeat (3) @(posedge i_ref_clk);
        chk({31'h0, o_ready_irq}, 32'h1);
        prog(KE, 8'h10, 8'h00);
        chk({31'h0, o_ready_irq}, 32'h0);
        span(DV * ST);
        i_gie <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        chk({31'h0, o_ready_irq}, 32'h0);
        stop_test();
    end
    // Watchdog sized well above the expected run of several hundred cycles
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        bad_count++;
        $display("ERROR %0t watchdog expired", $time);
        stop_test();
    end
endmodule // bec_ctrl_tb
`default_nettype wire
